// >>> rtl/encoder_image_access.sv
// encoder input block: synchronous-serial reader, two comparators, register channel
// What this block does
// [R1] Exchange an eight-byte input image and an eight-byte output image with controller.
// [R2] Halt bit 0 reads encoder cyclically; halt bit 1 suspends encoder traffic.
// [R3] Comparator disabled holds its three flags at 0; enabled they follow comparison.
// [R4] Clear bit 1 resets that comparator's sticky flag unless position equals its compare value; 0 leaves it alone.
// [R5] Comparator A equal flag is 1 exactly while position equals compare value A.
// [R6] Write request overwrites the addressed compare register with the write data; a write to position is refused.
// [R7] Write request dropping to 0 clears the write acknowledge.
// [R8] Acknowledge 0 accepts one write and sets; acknowledge 1 ignores further writes.
// [R9] Write-succeeded flag tells whether the requested write was carried out.
// [R10] Read data shows the register at the read address when not aborted.
// [R11] Read address echo names the register the read data belong to.
// [R12] Unreadable address sets read abort; successful read clears it.
// [R13] Sticky flag sets on first equality and stays until cleared.
// [R14] Relational flag is 1 when position is at or above compare value.
// [R15] Halted status is 1 while halted, 0 while reading cyclically.
// [R16] Encoder fault flag is 1 on a faulty encoder line, 0 when present.
// [R17] Comparator B behaves like A using compare value B.
`timescale 1ns/1ps
`include "enc_image_defs.svh"
module encoder_image_access (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [63:0] output_image_in,
  input wire logic encoder_data_in,
  output logic encoder_clk_out,
  output logic [63:0] input_image_out
);
  localparam int HALF_CYC = `SSI_HALF_CYC;
  localparam int PAUSE_CYC = `PAUSE_CYC;

  // ----------------------------------------
  // output image fields
  // ----------------------------------------
  logic halt_request;
  logic cmp_a_enable;
  logic cmp_a_clear;
  logic cmp_b_enable;
  logic cmp_b_clear;
  logic write_request;
  enc_image_pkg::reg_addr_t read_address;
  enc_image_pkg::reg_addr_t write_address;
  enc_image_pkg::word_t write_data;

  // field split of the controller's image
  assign halt_request = output_image_in[`OI_HALT];
  assign cmp_a_enable = output_image_in[`OI_CMP_A_EN];
  assign cmp_a_clear = output_image_in[`OI_CMP_A_CLR];
  assign cmp_b_enable = output_image_in[`OI_CMP_B_EN];
  assign cmp_b_clear = output_image_in[`OI_CMP_B_CLR];
  assign write_request = output_image_in[`OI_WR_REQ];
  assign read_address = output_image_in[`OI_RD_ADDR_LSB +: 6];
  assign write_address = output_image_in[`OI_WR_ADDR_LSB +: 6];
  assign write_data = output_image_in[`OI_WR_DATA_LSB +: 32];

  // ----------------------------------------
  // serial encoder reader
  // ----------------------------------------
  enc_image_pkg::ssi_state_e state;
  enc_image_pkg::ssi_state_e next_state;
  logic [8:0] timer;
  logic [8:0] next_timer;
  logic [5:0] bit_cnt;
  logic [5:0] next_bit_cnt;
  logic [31:0] shift;
  logic [31:0] next_shift;
  logic [31:0] position_value;
  logic [31:0] next_position_value;
  logic encoder_signal_fault;
  logic next_encoder_signal_fault;
  logic next_encoder_clk;

  // frame starts only after the monoflop pause, so a halt never cuts a frame short
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_position_value = position_value;
    next_encoder_signal_fault = encoder_signal_fault;
    next_encoder_clk = encoder_clk_out;
    unique case (state)
      enc_image_pkg::ST_IDLE: begin
        if (timer != 9'h000) begin
          next_timer = timer - 9'h001;
        end else if (!halt_request) begin // R2
          // idle line must be high; a low line means a broken cable
          next_encoder_signal_fault = ~encoder_data_in; // R16
          next_encoder_clk = 1'b0;
          next_timer = 9'(HALF_CYC - 1);
          next_bit_cnt = 6'h00;
          next_state = enc_image_pkg::ST_SHIFT;
        end
      end
      enc_image_pkg::ST_SHIFT: begin
        if (timer != 9'h000) begin
          next_timer = timer - 9'h001;
        end else begin
          next_timer = 9'(HALF_CYC - 1);
          next_encoder_clk = ~encoder_clk_out;
          if (!encoder_clk_out) begin
            // data sampled msb first on each rising clock edge
            next_shift = {shift[30:0], encoder_data_in};
            next_bit_cnt = bit_cnt + 6'h01;
            if (bit_cnt == 6'(`POS_BITS - 1)) begin
              next_position_value = {shift[30:0], encoder_data_in};
              next_timer = 9'(PAUSE_CYC - 1);
              next_state = enc_image_pkg::ST_IDLE;
            end
          end
        end
      end
    endcase
  end

  // reader state registers; clock line idles high
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= enc_image_pkg::ST_IDLE;
      timer <= 9'h000;
      bit_cnt <= 6'h00;
      shift <= 32'h0000_0000;
      position_value <= `RST_POSITION;
      encoder_signal_fault <= 1'b0;
      encoder_clk_out <= 1'b1;
    end else begin
      state <= next_state;
      timer <= next_timer;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      position_value <= next_position_value;
      encoder_signal_fault <= next_encoder_signal_fault;
      encoder_clk_out <= next_encoder_clk;
    end
  end

  // ----------------------------------------
  // comparators
  // ----------------------------------------
  logic cmp_a_equal;
  logic cmp_a_at_or_above;
  logic cmp_a_hit_latched;
  logic cmp_b_equal;
  logic cmp_b_at_or_above;
  logic cmp_b_hit_latched;
  enc_image_pkg::word_t compare_value_a;
  enc_image_pkg::word_t compare_value_b;

  // two identical channels on the shared position value
  compare_channel cmp_a_inst ( // R3 R4 R5 R13 R14
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(cmp_a_enable),
    .clear_in(cmp_a_clear),
    .position_in(position_value),
    .compare_in(compare_value_a),
    .equal_out(cmp_a_equal),
    .at_or_above_out(cmp_a_at_or_above),
    .hit_latched_out(cmp_a_hit_latched)
  );
  compare_channel cmp_b_inst ( // R17
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(cmp_b_enable),
    .clear_in(cmp_b_clear),
    .position_in(position_value),
    .compare_in(compare_value_b),
    .equal_out(cmp_b_equal),
    .at_or_above_out(cmp_b_at_or_above),
    .hit_latched_out(cmp_b_hit_latched)
  );

  // ----------------------------------------
  // register channel
  // ----------------------------------------
  enc_image_pkg::word_t next_compare_value_a;
  enc_image_pkg::word_t next_compare_value_b;
  logic write_acknowledge;
  logic next_write_acknowledge;
  logic write_succeeded;
  logic next_write_succeeded;
  enc_image_pkg::word_t read_data;
  enc_image_pkg::word_t next_read_data;
  enc_image_pkg::reg_addr_t read_echo;
  enc_image_pkg::reg_addr_t next_read_echo;
  logic read_abort;
  logic next_read_abort;
  logic write_accept;

  // a level request is taken once; the acknowledge blocks repeats
  assign write_accept = write_request & ~write_acknowledge; // R8

  // position is read-only, so writing it is refused
  always_comb begin
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    next_write_succeeded = write_succeeded;
    next_write_acknowledge = write_request & (write_acknowledge | write_accept); // R7 R8
    if (write_accept) begin
      next_write_succeeded = 1'b1; // R9
      if (write_address == `REG_COMPARE_A) begin
        next_compare_value_a = write_data; // R6
      end else if (write_address == `REG_COMPARE_B) begin
        next_compare_value_b = write_data; // R6
      end else begin
        next_write_succeeded = 1'b0; // R9
      end
    end
    next_read_echo = read_address; // R11
    next_read_abort = 1'b0; // R12
    next_read_data = 32'h0000_0000;
    if (read_address == `REG_POSITION) begin
      next_read_data = position_value; // R10
    end else if (read_address == `REG_COMPARE_A) begin
      next_read_data = compare_value_a; // R10
    end else if (read_address == `REG_COMPARE_B) begin
      next_read_data = compare_value_b; // R10
    end else begin
      next_read_abort = 1'b1; // R12
    end
  end

  // channel registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_value_a <= `RST_COMPARE;
      compare_value_b <= `RST_COMPARE;
      write_acknowledge <= 1'b0;
      write_succeeded <= 1'b0;
      read_data <= 32'h0000_0000;
      read_echo <= 6'h00;
      read_abort <= 1'b0;
    end else begin
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      write_acknowledge <= next_write_acknowledge;
      write_succeeded <= next_write_succeeded;
      read_data <= next_read_data;
      read_echo <= next_read_echo;
      read_abort <= next_read_abort;
    end
  end

  // ----------------------------------------
  // input image
  // ----------------------------------------
  logic [63:0] next_input_image;
  logic halted_status;

  // halted only once the reader has come to rest in idle
  assign halted_status = halt_request & (state == enc_image_pkg::ST_IDLE) & (timer == 9'h000); // R15

  // packs every status into the eight returned bytes; spare bits read zero
  always_comb begin
    next_input_image = 64'h0000_0000_0000_0000;
    next_input_image[`II_RD_ABORT] = read_abort; // R1
    next_input_image[`II_WR_ACK] = write_acknowledge;
    next_input_image[`II_WR_OK] = write_succeeded;
    next_input_image[`II_HALTED] = halted_status;
    next_input_image[`II_FAULT] = encoder_signal_fault;
    next_input_image[`II_RD_ECHO_LSB +: 6] = read_echo;
    next_input_image[`II_CMP_A_EQ] = cmp_a_equal;
    next_input_image[`II_CMP_A_GE] = cmp_a_at_or_above;
    next_input_image[`II_CMP_A_HIT] = cmp_a_hit_latched;
    next_input_image[`II_CMP_B_EQ] = cmp_b_equal;
    next_input_image[`II_CMP_B_GE] = cmp_b_at_or_above;
    next_input_image[`II_CMP_B_HIT] = cmp_b_hit_latched;
    next_input_image[`II_RD_DATA_LSB +: 32] = read_data;
  end

  // image register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_image_out <= 64'h0000_0000_0000_0000;
    end else begin
      input_image_out <= next_input_image;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  ack_set_a: assert property (write_request && !write_acknowledge |=> write_acknowledge) // R8
    else $error("write acknowledge not set");
  ack_drop_a: assert property (!write_request |=> !write_acknowledge) // R7
    else $error("write acknowledge not cleared");
  write_once_a: assert property (write_request && write_acknowledge |=> $stable(compare_value_a)) // R8
    else $error("repeated write was taken");
  write_data_a: assert property (write_accept && write_address == `REG_COMPARE_B // R6
      |=> compare_value_b == $past(write_data) && write_succeeded)
    else $error("compare value b not written");
  write_refused_a: assert property (write_accept && write_address == `REG_POSITION |=> !write_succeeded) // R9
    else $error("read-only write reported success");
  read_path_a: assert property (read_address == `REG_COMPARE_A // R10
      |=> read_data == $past(compare_value_a) && !read_abort && read_echo == `REG_COMPARE_A)
    else $error("read data or echo wrong");
  read_abort_a: assert property (read_address > `REG_COMPARE_B |=> read_abort ##1 input_image_out[`II_RD_ABORT]) // R12
    else $error("read abort missing");
  cmp_off_a: assert property (!cmp_a_enable |=> !cmp_a_equal && !cmp_a_at_or_above && !cmp_a_hit_latched) // R3
    else $error("disabled comparator flag set");
  cmp_equal_a: assert property (cmp_a_enable && position_value == compare_value_a |=> cmp_a_equal) // R5
    else $error("equality flag missing");
  cmp_rel_a: assert property (cmp_b_enable && position_value < compare_value_b |=> !cmp_b_at_or_above) // R14
    else $error("relational flag wrong");
  sticky_hold_a: assert property (cmp_a_hit_latched && cmp_a_enable && !cmp_a_clear |=> cmp_a_hit_latched) // R13
    else $error("sticky flag lost");
  sticky_clear_a: assert property (cmp_b_enable && cmp_b_clear && position_value != compare_value_b // R4
      |=> !cmp_b_hit_latched)
    else $error("sticky flag not cleared");
  halt_hold_a: assert property (halt_request && state == enc_image_pkg::ST_IDLE && timer == 9'h000 // R2
      |=> state == enc_image_pkg::ST_IDLE ##1 (input_image_out[`II_HALTED] || !halt_request))
    else $error("reader ran while halted");
  fault_set_a: assert property (state == enc_image_pkg::ST_IDLE && timer == 9'h000 && !halt_request // R16
      && !encoder_data_in |=> encoder_signal_fault ##1 input_image_out[`II_FAULT])
    else $error("encoder fault not flagged");

  write_cover_c: cover property (write_accept ##1 write_acknowledge ##[1:8] !write_acknowledge);
  frame_cover_c: cover property (state == enc_image_pkg::ST_SHIFT ##1 state == enc_image_pkg::ST_SHIFT [*8]);
  hit_cover_c: cover property (cmp_a_hit_latched && !cmp_a_equal);
  abort_cover_c: cover property (read_abort ##1 !read_abort);
endmodule

// >>> rtl/enc_image_defs.svh
// constants of the encoder process-image block: timing, image layout, register map
`ifndef ENC_IMAGE_DEFS_SVH
`define ENC_IMAGE_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_FREQ_MHZ 10
`define SSI_HALF_NS 500
`define SSI_HALF_CYC ((`SSI_HALF_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define PAUSE_US 30
`define PAUSE_CYC (`PAUSE_US * `CLK_FREQ_MHZ)
`define POS_BITS 32

// ----------------------------------------
// register indices (6-bit address)
// ----------------------------------------
`define REG_POSITION 6'h00
`define REG_COMPARE_A 6'h01
`define REG_COMPARE_B 6'h02
`define RST_COMPARE 32'h0000_0000
`define RST_POSITION 32'h0000_0000

// ----------------------------------------
// output image (controller to module) bit positions
// ----------------------------------------
`define OI_HALT 0
`define OI_CMP_A_EN 1
`define OI_CMP_A_CLR 2
`define OI_CMP_B_EN 3
`define OI_CMP_B_CLR 4
`define OI_WR_REQ 5
`define OI_RD_ADDR_LSB 8
`define OI_WR_ADDR_LSB 16
`define OI_WR_DATA_LSB 32

// ----------------------------------------
// input image (module to controller) bit positions
// ----------------------------------------
`define II_RD_ABORT 0
`define II_WR_ACK 1
`define II_WR_OK 2
`define II_HALTED 3
`define II_FAULT 4
`define II_RD_ECHO_LSB 8
`define II_CMP_A_EQ 16
`define II_CMP_A_GE 17
`define II_CMP_A_HIT 18
`define II_CMP_B_EQ 19
`define II_CMP_B_GE 20
`define II_CMP_B_HIT 21
`define II_RD_DATA_LSB 32

`endif

// >>> rtl/enc_image_pkg.sv
// types of the encoder process-image block
package enc_image_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } ssi_state_e;
  typedef logic [5:0] reg_addr_t;
  typedef logic [31:0] word_t;
endpackage

// >>> rtl/compare_channel.sv
// one position comparator with equality, relational and sticky-match outputs
`timescale 1ns/1ps
module compare_channel (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic clear_in,
  input wire logic [31:0] position_in,
  input wire logic [31:0] compare_in,
  output logic equal_out,
  output logic at_or_above_out,
  output logic hit_latched_out
);
  logic next_equal;
  logic next_at_or_above;
  logic next_hit;

  // disabled comparator forces all three flags low; a match beats a clear
  always_comb begin
    next_equal = 1'b0; // R3
    next_at_or_above = 1'b0; // R3
    next_hit = 1'b0; // R3
    if (enable_in) begin
      next_equal = (position_in == compare_in); // R5
      next_at_or_above = (position_in >= compare_in); // R14
      next_hit = (hit_latched_out & ~clear_in) | next_equal; // R4 R13
    end
  end

  // flags registered so that the image sees glitch-free values
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      equal_out <= 1'b0;
      at_or_above_out <= 1'b0;
      hit_latched_out <= 1'b0;
    end else begin
      equal_out <= next_equal;
      at_or_above_out <= next_at_or_above;
      hit_latched_out <= next_hit;
    end
  end
endmodule

// >>> bench/encoder_model.sv
// behavioural absolute encoder on the far side of the synchronous-serial link
`timescale 1ns/1ps
module encoder_model (
  input wire logic enc_clk_in,
  input wire logic [31:0] position_in,
  input wire logic cable_broken_in,
  output logic data_out,
  output int frame_count_out
);
  logic active = 1'b0;
  logic [31:0] word = 32'h0;
  int idx = 0;
  int count = 0;

  // ----------------------------------------
  // frame sequencing
  // ----------------------------------------
  // one process owns the frame state so nothing has two drivers
  // first fall opens a frame and freezes the word, later falls step msb first;
  // last bit held for 1000 ns after the final rise, so no sampling race
  always @(enc_clk_in) begin
    if (enc_clk_in === 1'b0) begin
      if (!active) begin
        active = 1'b1;
        word = position_in;
        idx = 31;
        count = count + 1;
      end else if (idx > 0) begin
        idx = idx - 1;
      end
    end else if (enc_clk_in === 1'b1 && active && idx == 0) begin
      active <= #1000 1'b0;
    end
  end

  assign frame_count_out = count;

  // broken cable pulls the line low, an idle line sits high
  assign data_out = cable_broken_in ? 1'b0 : (active ? word[idx] : 1'b1);
endmodule

// >>> bench/encoder_image_access_test.sv
// self-checking bench of the encoder process-image block
`timescale 1ns/1ps
`define CHECK(got, exp) check_val(64'(got), 64'(exp))
module encoder_image_access_test;
  logic sys_clk_in;
  logic rst_n_in;
  logic [63:0] oi;
  logic [63:0] ii;
  logic enc_clk;
  logic enc_data;
  logic [31:0] enc_word;
  logic broken;
  int frames;
  int n_mismatch;
  int check_count;
  int f0;
  int base;
  logic [31:0] seed;
  logic [31:0] regs [0:2];
  logic [31:0] pos;
  logic [31:0] d;
  logic [5:0] a;

  encoder_image_access dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .output_image_in(oi),
    .encoder_data_in(enc_data), .encoder_clk_out(enc_clk), .input_image_out(ii));
  encoder_model enc_u (.enc_clk_in(enc_clk), .position_in(enc_word), .cable_broken_in(broken),
    .data_out(enc_data), .frame_count_out(frames));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected {read data, address echo, abort}; unreadable places give zero data
  function automatic logic [38:0] exp_rd(input logic [5:0] ad);
    return (ad > 6'h02) ? {32'h0, ad, 1'b1} : {regs[ad[1:0]], ad, 1'b0};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // bounded wait on one status bit; a hang ends the run
  task automatic wait_bit(input int idx, input logic val);
    int k;
    k = 0;
    check_count++;
    while (ii[idx] !== val && k < 20) begin
      tick(1);
      k++;
    end
    if (ii[idx] !== val) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, ii[idx], val);
      stop_test();
    end
  endtask

  task automatic wait_frame();
    int k;
    int fs;
    k = 0;
    fs = frames;
    check_count++;
    while (frames == fs && k < 2000) begin
      tick(1);
      k++;
    end
    if (frames == fs) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, frames, fs + 1);
      stop_test();
    end
  endtask

  // one write handshake, then a second request during acknowledge that must be ignored
  task automatic wr(input logic [5:0] ad, input logic [31:0] v);
    oi[21:16] = ad;
    oi[63:32] = v;
    oi[5] = 1'b1;
    wait_bit(1, 1'b1);
    `CHECK(ii[2], (ad == 6'h01 || ad == 6'h02));
    if (ad == 6'h01 || ad == 6'h02) begin
      regs[ad[1:0]] = v;
    end
    oi[21:16] = {4'h0, ~ad[1:0]};
    oi[63:32] = ~v;
    tick(4);
    oi[5] = 1'b0;
    wait_bit(1, 1'b0);
  endtask

  task automatic rd(input logic [5:0] ad);
    oi[13:8] = ad;
    tick(3);
    `CHECK({ii[63:32], ii[13:8], ii[0]}, exp_rd(ad));
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    seed = 32'h23eac3c1;
    n_mismatch = 0;
    check_count = 0;
    rst_n_in = 1'b0;
    oi = 64'h1;
    broken = 1'b0;
    enc_word = 32'h0;
    for (int k = 0; k < 3; k++) begin
      regs[k] = 32'h0;
    end
    tick(1);
    `CHECK(ii, 64'h0);
    `CHECK(enc_clk, 1'b1);
    // reset spans three rising edges before release
    tick(2);
    rst_n_in = 1'b1;
    tick(5);
    `CHECK({ii[3], enc_clk, frames}, {1'b1, 1'b1, 32'h0});
    // register channel: corner addresses first, then random ones
    for (int i = 0; i < 10; i++) begin
      d = rnd();
      a = (i < 4) ? 6'(i) : ((i == 4) ? 6'h3f : d[5:0]);
      wr(a, rnd());
      for (int k = 0; k < 4; k++) begin
        rd(6'(k));
      end
      rd(d[13:8]);
    end
    // one frame, then halt: position appears and traffic stops
    pos = rnd();
    pos[31:30] = 2'b01;
    enc_word = pos;
    oi[0] = 1'b0;
    wait_frame();
    tick(3);
    `CHECK(ii[3], 1'b0);
    tick(400);
    oi[0] = 1'b1;
    tick(400);
    regs[0] = pos;
    rd(6'h00);
    `CHECK({ii[3], enc_clk}, 2'b11);
    `CHECK({ii[31:22], ii[15:14], ii[7:5]}, 15'h0);
    f0 = frames;
    tick(700);
    `CHECK(frames, f0);
    // both comparators around the frozen position
    for (int ch = 0; ch < 2; ch++) begin
      base = 16 + 3 * ch;
      wr(6'(ch + 1), pos);
      tick(3);
      `CHECK(ii[base +: 3], 3'b000);
      oi[1 + 2 * ch] = 1'b1;
      tick(3);
      `CHECK(ii[base +: 3], 3'b111);
      wr(6'(ch + 1), pos + 32'h1);
      tick(3);
      `CHECK(ii[base +: 3], 3'b100);
      oi[2 + 2 * ch] = 1'b1;
      tick(3);
      `CHECK(ii[base +: 3], 3'b000);
      oi[2 + 2 * ch] = 1'b0;
      wr(6'(ch + 1), pos - 32'h1);
      tick(3);
      `CHECK(ii[base +: 3], 3'b010);
      oi[1 + 2 * ch] = 1'b0;
      tick(3);
      `CHECK(ii[base +: 3], 3'b000);
    end
    // broken cable seen at a frame start, then a healthy frame clears it
    broken = 1'b1;
    oi[0] = 1'b0;
    wait_frame();
    tick(3);
    `CHECK(ii[4:3], 2'b10);
    broken = 1'b0;
    wait_frame();
    tick(3);
    `CHECK(ii[4], 1'b0);
    oi[0] = 1'b1;
    stop_test();
  end
endmodule
